/* File: core/pin_sync.sv */
/*
  two-flop synchroniser for a group of pin inputs.
  assumes: inputs asynchronous to clk; q is read by logic, s1 never.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } state_s;

  state_s st_q;
  state_s st_d;

  // two stages, second one is the only reader of the first
  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= {RST_VAL, RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule

/* File: core/sample_fifo.sv */
/*
  flop based fifo with valid/ready on both sides.
  assumes: DEPTH is a power of two; single clock.
*/
`timescale 1ns/1ps
module sample_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             count;
  } state_s;

  state_s st_q;
  state_s st_d;
  logic   push;
  logic   pop;

  // honest full and empty from the fill count
  assign in_ready  = (st_q.count != (AW+1)'(DEPTH));
  assign out_valid = (st_q.count != '0);
  assign out_data  = st_q.mem[st_q.rd];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer and count update
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr] = in_data;
      st_d.wr           = st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = st_q.rd + 1'b1;
    end
    if (push && !pop) begin
      st_d.count = st_q.count + 1'b1;
    end else if (pop && !push) begin
      st_d.count = st_q.count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

/* File: core/test_mux_pattern_generator.sv */
/*
  dac test logic: spi register slave, lvds skew test mux, temperature
  diode selector and 64 sample repeating pattern generator.
  assumes: spi pins asynchronous to clk, sck below clk/16; lvds_sample
  and dac_ready come from logic on clk; test pins are wired to an
  analogue switch driven by the enable outputs.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - bit 0 set picks inverted pair, clear the next-higher
// - bits 5:1 address pair, a high down b
// - bit 6 routes selected pair to test pins
// - skew register resets to zero
// - temp bit 0 puts diode on test pins unless skew bit 6 also set
// - temp bit 1 picks biased or unbiased diode
// - temperature register resets to zero
// - 64 samples replay regardless of lvds input
// - 128 bytes, msb first, replay in order
// - single bytes or bursts store alike
// - pattern enable sources dac from memory
// - replay runs until either enable cleared
// - reading data address shifts bytes out sdo
// - read-back may start at rotated position
// - pattern registers reset to zero
// - data enable cleared forces mid-scale
// - port mode zero dual, one single
module test_mux_pattern_generator #(
  parameter int LANES    = test_mux_pkg::LANES,
  parameter int SAMPLE_W = test_mux_pkg::SAMPLE_W,
  parameter int BYTES    = test_mux_pkg::PATTERN_BYTES,
  parameter int DEPTH    = test_mux_pkg::FIFO_DEPTH
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                spi_cs_n,
  input  wire logic                spi_sck,
  input  wire logic                spi_sdi,
  output logic                     spi_sdo,
  output logic                     spi_sdo_oe_n,
  input  wire logic [LANES-1:0]    port_a_lanes,
  input  wire logic [LANES-1:0]    port_b_lanes,
  input  wire logic                data_clock_input,
  input  wire logic [SAMPLE_W-1:0] lvds_sample,
  input  wire logic                dac_ready,
  output logic      [SAMPLE_W-1:0] dac_sample,
  output logic                     test_output_p,
  output logic                     test_output_n,
  output logic                     test_output_oe_n,
  output logic                     skew_mux_enable,
  output logic      [4:0]          skew_pair_address,
  output logic                     skew_pair_invert_select,
  output logic                     temp_diode_enable,
  output logic                     temp_diode_select,
  output logic                     pattern_enable,
  output logic                     data_enable,
  output logic                     port_mode_single,
  output logic                     output_clock_divide_select
);

  localparam int PTR_W = $clog2(BYTES);
  localparam int CHAIN = 2 * LANES + 1;

  typedef enum logic {
    PH_CMD,
    PH_DATA
  } spi_phase_e;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic                      sck_prev;
    spi_phase_e                phase;
    logic [2:0]                bit_cnt;
    logic                      rd_mode;
    logic [6:0]                addr;
    logic [7:0]                shift_in;
    logic [7:0]                shift_out;
    logic                      load_pend;
    test_mux_pkg::skew_cfg_s   skew;
    test_mux_pkg::temp_cfg_s   temp;
    logic                      pg_en;
    logic                      div_sel;
    logic                      pmode;
    logic                      data_en;
    logic [BYTES-1:0][7:0]     mem;
    logic [PTR_W-1:0]          ptr;
    logic [SAMPLE_W-1:0]       dac;
  } state_s;

  state_s                  st_q;
  state_s                  st_d;
  test_mux_pkg::reg_req_s  req;
  logic [2:0]              pins_s;
  logic                    cs_n_s;
  logic                    sck_s;
  logic                    sdi_s;
  logic                    sck_rise;
  logic                    sck_fall;
  logic [7:0]              byte_in;
  logic [7:0]              rdata;
  logic                    data_acc;
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic                    fifo_out_ready;
  logic [SAMPLE_W-1:0]     fifo_out_data;
  logic [SAMPLE_W-1:0]     fifo_in_data;
  logic [CHAIN-1:0]        chain;
  logic [5:0]              chain_idx;
  logic                    skew_bit;

  // ****************************************
  // spi pin synchronisers
  // ****************************************
  pin_sync #(
    .W       (3),
    .RST_VAL (3'h4)
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({spi_cs_n, spi_sck, spi_sdi}),
    .q     (pins_s)
  );

  assign cs_n_s   = pins_s[2];
  assign sck_s    = pins_s[1];
  assign sdi_s    = pins_s[0];
  assign sck_rise = sck_s & ~st_q.sck_prev;
  assign sck_fall = ~sck_s & st_q.sck_prev;
  assign byte_in  = {st_q.shift_in[6:0], sdi_s};

  // data port usable only while replay is stopped
  assign data_acc = ~st_q.pg_en && (st_q.addr == test_mux_pkg::ADDR_PGEN_DATA);

  // ****************************************
  // register read mux
  // ****************************************
  always_comb begin
    rdata = '0;
    case (st_q.addr)
      test_mux_pkg::ADDR_SKEW: begin
        rdata[6:0] = st_q.skew;
      end
      test_mux_pkg::ADDR_TEMP: begin
        rdata[1:0] = st_q.temp;
      end
      test_mux_pkg::ADDR_PGEN_CTL: begin
        rdata[test_mux_pkg::PATTERN_ENABLE_BIT] = st_q.pg_en;
      end
      test_mux_pkg::ADDR_PGEN_DATA: begin
        rdata = data_acc ? st_q.mem[st_q.ptr] : 8'h00;
      end
      test_mux_pkg::ADDR_CLK_OUT: begin
        rdata[test_mux_pkg::CLK_DIV_BIT] = st_q.div_sel;
      end
      test_mux_pkg::ADDR_DATA_CTL: begin
        rdata[test_mux_pkg::PMODE_BIT]   = st_q.pmode;
        rdata[test_mux_pkg::DATA_EN_BIT] = st_q.data_en;
      end
      default: begin
        rdata = '0;
      end
    endcase
  end

  // ****************************************
  // next state: spi engine, registers, replay
  // ****************************************
  always_comb begin
    st_d           = st_q;
    req            = '0;
    req.addr       = st_q.addr;
    req.wdata      = byte_in;
    st_d.sck_prev  = sck_s;
    st_d.load_pend = 1'b0;

    // spi framing: command byte then data bytes on one address
    if (cs_n_s) begin
      st_d.phase   = PH_CMD;
      st_d.bit_cnt = '0;
    end else begin
      if (st_q.load_pend) begin
        st_d.shift_out = rdata;
      end
      if (sck_rise) begin
        st_d.shift_in = byte_in;
        st_d.bit_cnt  = st_q.bit_cnt + 3'd1;
        if (st_q.bit_cnt == 3'd7) begin
          if (st_q.phase == PH_CMD) begin
            st_d.rd_mode   = byte_in[test_mux_pkg::SPI_READ_BIT];
            st_d.addr      = byte_in[6:0];
            st_d.phase     = PH_DATA;
            st_d.load_pend = byte_in[test_mux_pkg::SPI_READ_BIT];
          end else if (st_q.rd_mode) begin
            req.adv        = 1'b1;
            st_d.load_pend = 1'b1;
          end else begin
            req.wr = 1'b1;
          end
        end
      end else if (sck_fall && st_q.phase == PH_DATA && st_q.rd_mode && st_q.bit_cnt != 3'd0) begin
        st_d.shift_out = {st_q.shift_out[6:0], 1'b0};
      end
    end

    // register writes
    if (req.wr) begin
      case (req.addr)
        test_mux_pkg::ADDR_SKEW: begin
          st_d.skew = test_mux_pkg::skew_cfg_s'(req.wdata[6:0]);
        end
        test_mux_pkg::ADDR_TEMP: begin
          st_d.temp = test_mux_pkg::temp_cfg_s'(req.wdata[1:0]);
        end
        test_mux_pkg::ADDR_PGEN_CTL: begin
          st_d.pg_en = req.wdata[test_mux_pkg::PATTERN_ENABLE_BIT];
        end
        test_mux_pkg::ADDR_CLK_OUT: begin
          st_d.div_sel = req.wdata[test_mux_pkg::CLK_DIV_BIT];
        end
        test_mux_pkg::ADDR_DATA_CTL: begin
          st_d.pmode   = req.wdata[test_mux_pkg::PMODE_BIT];
          st_d.data_en = req.wdata[test_mux_pkg::DATA_EN_BIT];
        end
        test_mux_pkg::ADDR_PGEN_DATA: begin
          if (data_acc) begin
            st_d.mem[st_q.ptr] = req.wdata;
            st_d.ptr           = st_q.ptr + 1'b1;
          end
        end
        default: begin
          st_d.pg_en = st_q.pg_en;
        end
      endcase
    end

    // a read of the data port moves the same circular pointer
    if (req.adv && data_acc) begin
      st_d.ptr = st_q.ptr + 1'b1;
    end

    // replay two bytes per sample, pointer rotates with it
    if (st_q.pg_en && fifo_in_ready) begin
      st_d.ptr = st_q.ptr + PTR_W'(2);
    end

    // dac source select
    if (!st_q.data_en) begin
      st_d.dac = test_mux_pkg::MID_SCALE;
    end else if (st_q.pg_en) begin
      if (fifo_out_valid && dac_ready) begin
        st_d.dac = fifo_out_data;
      end
    end else if (dac_ready) begin
      st_d.dac = lvds_sample;
    end
  end

  // all state resets to zero, registers read 0x00
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // pattern sample buffer
  // ****************************************
  // msb byte sits first in memory
  assign fifo_in_data   = {st_q.mem[st_q.ptr], st_q.mem[st_q.ptr + 1'b1]};
  // drains to the dac, or flushes stale samples while stopped
  assign fifo_out_ready = (dac_ready & st_q.data_en) | ~st_q.pg_en;

  sample_fifo #(
    .W     (SAMPLE_W),
    .DEPTH (DEPTH)
  ) u_sample_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (st_q.pg_en),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ****************************************
  // skew test mux
  // ****************************************
  // chain runs a top lane down, clock, then b top down
  for (genvar i = 0; i < LANES; i++) begin : g_chain
    assign chain[i]           = port_a_lanes[LANES-1-i];
    assign chain[LANES+1+i]   = port_b_lanes[LANES-1-i];
  end
  assign chain[LANES] = data_clock_input;

  // raw lane path on purpose: a flop would hide the skew
  assign chain_idx = {1'b0, st_q.skew.address} + {5'b0, ~st_q.skew.invert};
  assign skew_bit  = st_q.skew.invert ? ~chain[chain_idx] : chain[chain_idx];

  // ****************************************
  // outputs
  // ****************************************
  assign spi_sdo      = st_q.shift_out[7];
  assign spi_sdo_oe_n = ~(~cs_n_s && st_q.phase == PH_DATA && st_q.rd_mode);

  // the mux owns the pins; the diode yields if both are set
  assign test_output_p    = st_q.skew.enable & skew_bit;
  assign test_output_n    = st_q.skew.enable & ~skew_bit;
  assign test_output_oe_n = ~st_q.skew.enable;
  assign temp_diode_enable = st_q.temp.enable & ~st_q.skew.enable;
  assign temp_diode_select = st_q.temp.select;

  assign skew_mux_enable            = st_q.skew.enable;
  assign skew_pair_address          = st_q.skew.address;
  assign skew_pair_invert_select    = st_q.skew.invert;
  assign pattern_enable             = st_q.pg_en;
  assign data_enable                = st_q.data_en;
  assign port_mode_single           = st_q.pmode;
  assign output_clock_divide_select = st_q.div_sel;
  assign dac_sample                 = st_q.dac;

endmodule

/* File: core/test_mux_pkg.sv */
/*
  constants and carrier types for the skew test mux, temperature diode
  selector and pattern generator.
  assumes: used by package::name only, never imported.
*/
package test_mux_pkg;

  // ****************************************
  // register offsets (spi address space)
  // ****************************************
  localparam logic [6:0] ADDR_CLK_OUT   = 7'h02;
  localparam logic [6:0] ADDR_DATA_CTL  = 7'h04;
  localparam logic [6:0] ADDR_SKEW      = 7'h18;
  localparam logic [6:0] ADDR_TEMP      = 7'h19;
  localparam logic [6:0] ADDR_PGEN_CTL  = 7'h1e;
  localparam logic [6:0] ADDR_PGEN_DATA = 7'h1f;

  // ****************************************
  // field positions
  // ****************************************
  localparam int SKEW_INV_BIT  = 0;
  localparam int SKEW_ADR_LSB  = 1;
  localparam int SKEW_EN_BIT   = 6;
  localparam int TEMP_EN_BIT   = 0;
  localparam int TEMP_SEL_BIT  = 1;
  localparam int PATTERN_ENABLE_BIT   = 0;
  localparam int CLK_DIV_BIT   = 5;
  localparam int PMODE_BIT     = 2;
  localparam int DATA_EN_BIT   = 3;
  localparam int SPI_READ_BIT  = 7;

  // ****************************************
  // reset values and sizes
  // ****************************************
  localparam logic [7:0]  REG_RESET       = 8'h00;
  localparam int          PATTERN_BYTES   = 128;
  localparam int          PATTERN_SAMPLES = 64;
  localparam int          SAMPLE_W        = 16;
  localparam int          LANES           = 16;
  localparam int          FIFO_DEPTH      = 16;
  localparam logic [15:0] MID_SCALE       = 16'h8000;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic       enable;
    logic [4:0] address;
    logic       invert;
  } skew_cfg_s;

  typedef struct packed {
    logic select;
    logic enable;
  } temp_cfg_s;

  typedef struct packed {
    logic       wr;
    logic       adv;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage

/* File: test/spi_host_model.sv */
/*
  spi host model: mode 0 frames, command byte then data bytes to one address.
  assumes: clk is the device clock; the bench fills txq and calls frame.
*/
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sck,
  output logic      sdi,
  input  wire logic sdo
);
  localparam int HALF = 10; // sck half period in clk cycles
  logic [7:0] txq [$];
  logic [7:0] rxq [$];
  // idle levels
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    sdi  = 1'b0;
  end
  // one byte msb first; sdi moves while sck low, sdo taken at the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi <= tx[i];
      repeat (HALF) @(posedge clk);
      rx[i] = sdo;
      sck <= 1'b1;
      repeat (HALF) @(posedge clk);
      sck <= 1'b0;
    end
  endtask
  // whole frame; command byte then the txq bytes, replies kept in rxq
  task automatic frame(input logic rd, input logic [6:0] addr);
    logic [7:0] rx;
    rxq.delete();
    cs_n <= 1'b0;
    repeat (3) @(posedge clk);
    xfer({rd, addr}, rx);
    foreach (txq[i]) begin
      xfer(txq[i], rx);
      rxq.push_back(rx);
    end
    repeat (HALF) @(posedge clk);
    cs_n <= 1'b1;
    sdi  <= ~sdi; // released line does not keep its last bit
    repeat (4) @(posedge clk);
  endtask
endmodule

/* File: test/test_mux_checker_asserts.sv */
/*
  concurrent checks on the test mux and pattern generator ports.
  assumes: bound to the top module; one clock, synchronous active low reset.
*/
`timescale 1ns/1ps
module test_mux_checker #(
  parameter int LANES    = 16,
  parameter int SAMPLE_W = 16
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                spi_cs_n,
  input wire logic                spi_sdo_oe_n,
  input wire logic [LANES-1:0]    port_a_lanes,
  input wire logic [LANES-1:0]    port_b_lanes,
  input wire logic                dac_ready,
  input wire logic [SAMPLE_W-1:0] dac_sample,
  input wire logic                test_output_p,
  input wire logic                test_output_n,
  input wire logic                test_output_oe_n,
  input wire logic                skew_mux_enable,
  input wire logic [4:0]          skew_pair_address,
  input wire logic                skew_pair_invert_select,
  input wire logic                temp_diode_enable,
  input wire logic                pattern_enable,
  input wire logic                data_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****************************************
  // dac stream
  // ****************************************
  a_mid_scale_out: assert property (
    !data_enable |=> dac_sample == test_mux_pkg::MID_SCALE) else $error("dac not mid-scale");
  a_sample_hold_stall: assert property (
    data_enable && !dac_ready |=> $stable(dac_sample)) else $error("dac sample moved without ready");
  a_change_needs_ready: assert property (
    data_enable && $changed(dac_sample) |-> $past(dac_ready)) else $error("dac sample changed unasked");
  // ****************************************
  // test pins and spi output
  // ****************************************
  a_temp_mux_excl: assert property (
    temp_diode_enable |-> !skew_mux_enable) else $error("diode and mux both on");
  a_pins_idle: assert property (
    !skew_mux_enable && !$past(skew_mux_enable) |-> test_output_oe_n && !test_output_p && !test_output_n)
    else $error("test pins active with mux off");
  a_oe_tracks_mux: assert property (
    skew_mux_enable && $past(skew_mux_enable) |-> !test_output_oe_n) else $error("test pins not driven");
  a_sdo_quiet: assert property (
    spi_cs_n [*5] |-> spi_sdo_oe_n) else $error("sdo driven while deselected");
  a_skew_low_pair: assert property (
    skew_mux_enable && !skew_pair_invert_select && skew_pair_address == 5'h1f
    |-> test_output_p == port_b_lanes[0]) else $error("last pair not lowest b lane");
  a_skew_top_inv: assert property (
    skew_mux_enable && skew_pair_invert_select && skew_pair_address == 5'h00
    |-> test_output_p == !port_a_lanes[LANES-1]) else $error("inverted top pair wrong");
  // main scenarios seen
  c_pattern_run: cover property (pattern_enable && data_enable && dac_ready);
  c_skew_on: cover property (skew_mux_enable);
  c_temp_on: cover property (temp_diode_enable);
  c_sdo_drive: cover property (!spi_sdo_oe_n);
endmodule

bind test_mux_pattern_generator test_mux_checker #(.LANES(LANES), .SAMPLE_W(SAMPLE_W)) u_chk (
  .clk(clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_sdo_oe_n(spi_sdo_oe_n),
  .port_a_lanes(port_a_lanes), .port_b_lanes(port_b_lanes), .dac_ready(dac_ready),
  .dac_sample(dac_sample), .test_output_p(test_output_p), .test_output_n(test_output_n),
  .test_output_oe_n(test_output_oe_n), .skew_mux_enable(skew_mux_enable),
  .skew_pair_address(skew_pair_address), .skew_pair_invert_select(skew_pair_invert_select),
  .temp_diode_enable(temp_diode_enable), .pattern_enable(pattern_enable), .data_enable(data_enable));

/* File: test/test_mux_pattern_generator_tb.sv */
/*
  self-checking bench: registers, skew mux, diode, pattern load and replay.
  assumes: spi_host_model as the far side; 200 MHz clock.
*/
`timescale 1ns/1ps
module test_mux_pattern_generator_tb;
  logic        clk, rst_n, cs_n, sck, sdi, sdo, sdo_oe_n, dci, rdy;
  logic [15:0] pa, pb, lvds, dac, prev;
  logic        tp, tn, toe, smx, sinv, ten, tsel, pen, den, psing, cdiv;
  logic [4:0]  sadr;
  logic [5:0]  sk [5] = '{6'h00, 6'h01, 6'h1f, 6'h21, 6'h3e};
  logic [7:0]  pat [128];
  int          miscompares, num_checks, n, t, r;

  spi_host_model u_host (.clk(clk), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo));
  test_mux_pattern_generator u_dut (
    .clk(clk), .rst_n(rst_n), .spi_cs_n(cs_n), .spi_sck(sck), .spi_sdi(sdi), .spi_sdo(sdo),
    .spi_sdo_oe_n(sdo_oe_n), .port_a_lanes(pa), .port_b_lanes(pb), .data_clock_input(dci),
    .lvds_sample(lvds), .dac_ready(rdy), .dac_sample(dac), .test_output_p(tp), .test_output_n(tn),
    .test_output_oe_n(toe), .skew_mux_enable(smx), .skew_pair_address(sadr),
    .skew_pair_invert_select(sinv), .temp_diode_enable(ten), .temp_diode_select(tsel),
    .pattern_enable(pen), .data_enable(den), .port_mode_single(psing), .output_clock_divide_select(cdiv));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.txq.delete();
    u_host.txq.push_back(d);
    u_host.frame(1'b0, a);
  endtask
  task automatic rd_burst(input logic [6:0] a, input int cnt);
    u_host.txq.delete();
    repeat (cnt) u_host.txq.push_back(8'h00);
    u_host.frame(1'b1, a);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    rd_burst(a, 1);
    check(u_host.rxq[0], e);
  endtask
  // lane chain: port a top down, data clock, port b top down
  function automatic logic lane(input int i);
    if (i < 16) return pa[15-i];
    if (i == 16) return dci;
    return pb[32-i];
  endfunction

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    pa = 16'ha5c3;
    pb = 16'h3c5a;
    dci = 1'b1;
    lvds = 16'h1234;
    rdy = 1'b1;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(dac, test_mux_pkg::MID_SCALE);
    check(toe, 1'b1);
    rd_chk(test_mux_pkg::ADDR_SKEW, 8'h00);
    rd_chk(test_mux_pkg::ADDR_TEMP, 8'h00);
    rd_chk(test_mux_pkg::ADDR_PGEN_CTL, 8'h00);
    rd_burst(test_mux_pkg::ADDR_PGEN_DATA, 2);
    check(u_host.rxq[0], 8'h00);
    check(u_host.rxq[1], 8'h00);
    $display("test reset done");
    for (int k = 0; k < 5; k++) begin
      wr(test_mux_pkg::ADDR_SKEW, {2'b01, sk[k]});
      check({smx, sadr, sinv}, {1'b1, sk[k]});
      check(tp, sk[k][0] ? !lane(sk[k][5:1]) : lane(sk[k][5:1] + 1));
      check(toe, 1'b0);
      rd_chk(test_mux_pkg::ADDR_SKEW, {2'b01, sk[k]});
    end
    wr(test_mux_pkg::ADDR_SKEW, 8'h00);
    check(toe, 1'b1);
    wr(test_mux_pkg::ADDR_TEMP, 8'h03);
    check({ten, tsel}, 2'b11);
    rd_chk(test_mux_pkg::ADDR_TEMP, 8'h03);
    wr(test_mux_pkg::ADDR_TEMP, 8'h01);
    check({ten, tsel}, 2'b10);
    wr(test_mux_pkg::ADDR_TEMP, 8'h00);
    wr(test_mux_pkg::ADDR_CLK_OUT, 8'h20);
    wr(test_mux_pkg::ADDR_DATA_CTL, 8'h04);
    check({cdiv, psing}, 2'b11);
    wr(test_mux_pkg::ADDR_CLK_OUT, 8'h00);
    wr(test_mux_pkg::ADDR_DATA_CTL, 8'h00);
    check({cdiv, psing}, 2'b00);
    wr(test_mux_pkg::ADDR_DATA_CTL, 8'h08);
    check(dac, 16'h1234);
    wr(test_mux_pkg::ADDR_DATA_CTL, 8'h00);
    check(dac, test_mux_pkg::MID_SCALE);
    wr(7'h30, 8'h5a);
    rd_chk(7'h30, 8'h00);
    $display("test registers done");
    // load: half single-byte frames, half one burst
    for (int i = 0; i < 128; i++) pat[i] = 8'(i * 3 + 1);
    for (int i = 0; i < 64; i++) wr(test_mux_pkg::ADDR_PGEN_DATA, pat[i]);
    u_host.txq.delete();
    for (int i = 64; i < 128; i++) u_host.txq.push_back(pat[i]);
    u_host.frame(1'b0, test_mux_pkg::ADDR_PGEN_DATA);
    rd_burst(test_mux_pkg::ADDR_PGEN_DATA, 128);
    for (int i = 0; i < 128; i++) check(u_host.rxq[i], pat[i]);
    rdy <= 1'b0;
    wr(test_mux_pkg::ADDR_PGEN_CTL, 8'h01);
    rd_chk(test_mux_pkg::ADDR_PGEN_DATA, 8'h00);
    wr(test_mux_pkg::ADDR_DATA_CTL, 8'h08);
    check(dac, test_mux_pkg::MID_SCALE);
    // replay with stalls while lvds input keeps moving
    n = 0;
    t = 0;
    prev = dac;
    while (n < 130 && t < 2000) begin
      @(posedge clk);
      t++;
      rdy <= (t % 5 != 0);
      lvds <= 16'(t);
      @(negedge clk);
      if (dac !== prev) begin
        check(dac, {pat[2 * (n % 64)], pat[2 * (n % 64) + 1]});
        n++;
        prev = dac;
      end
    end
    check(n, 130);
    if (t >= 2000) give_verdict();
    wr(test_mux_pkg::ADDR_DATA_CTL, 8'h00);
    check(dac, test_mux_pkg::MID_SCALE);
    wr(test_mux_pkg::ADDR_PGEN_CTL, 8'h00);
    $display("test replay done");
    rd_burst(test_mux_pkg::ADDR_PGEN_DATA, 128);
    r = 0;
    for (int i = 0; i < 128; i++) if (pat[i] === u_host.rxq[0]) r = i;
    check(r % 2, 0);
    for (int i = 0; i < 128; i++) check(u_host.rxq[i], pat[(i + r) % 128]);
    $display("test read-back done");
    give_verdict();
  end
endmodule
